/* rtl/art_pkg.sv */
package art_pkg;
  // register byte offsets
  localparam logic [7:0] ART_OFF_RES_LOW   = 8'h00;
  localparam logic [7:0] ART_OFF_RES_HIGH  = 8'h04;
  localparam logic [7:0] ART_OFF_CTRL_B    = 8'h08;
  localparam logic [7:0] ART_OFF_DIN_LOW   = 8'h0C;
  localparam logic [7:0] ART_OFF_DIN_HIGH  = 8'h10;
  localparam logic [7:0] ART_OFF_MISC      = 8'h14;
  localparam logic [7:0] ART_OFF_CTRL_A    = 8'h18;
  localparam logic [7:0] ART_OFF_STATUS    = 8'h1C;
  // converter_control_b fields
  localparam int ART_CB_BIPOLAR    = 7;
  localparam int ART_CB_CMP_HI     = 6;
  localparam int ART_CB_CMP_LO     = 4;
  localparam int ART_CB_TRIG_HI    = 2;
  localparam int ART_CB_TRIG_LO    = 0;
  localparam logic [7:0] ART_CB_WMASK   = 8'hF7;
  // digital_input_off_high fields
  localparam logic [7:0] ART_DIH_WMASK  = 8'h70;
  localparam int ART_DIH_LO        = 4;
  localparam int ART_DIH_HI        = 6;
  // analog_misc_control fields
  localparam int ART_MISC_EXT_REF  = 2;
  localparam int ART_MISC_INT_OUT  = 1;
  localparam int ART_MISC_ISRC     = 0;
  localparam logic [7:0] ART_MISC_WMASK = 8'h07;
  // own control register fields
  localparam int ART_CA_ON         = 0;
  localparam int ART_CA_AUTO       = 1;
  localparam int ART_CA_LEFT       = 2;
  localparam int ART_CA_START      = 3;
  // status register fields
  localparam int ART_ST_DONE       = 0;
  localparam int ART_ST_BUSY       = 1;
  localparam int ART_ST_LOCK       = 2;
  localparam logic [2:0] ART_TRIG_FREE  = 3'h0;
  localparam logic [9:0] ART_RES_SAT    = 10'h3FF;
  localparam logic [7:0] ART_BYTE_ZERO  = 8'h00;
  localparam logic [1:0] ART_RESP_OKAY  = 2'h0;
  localparam logic [1:0] ART_RESP_SLVERR = 2'h2;
endpackage

/* rtl/art_result_trigger.sv */
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
// Notes on behaviour
// - right aligned: bits 9:8 in high byte
// - left aligned: bits 9:2 high, 1:0 low
// - low read locks both until high read
// - result loaded on completion, resets zero
// - unipolar unsigned, saturates when input reversed
// - bipolar gives two's complement nine plus sign
// - trigger source ignored without auto trigger
// - auto trigger on rising flag edge
// - source switch clear-to-set counts as edge
// - selecting free running never triggers itself
// - trigger source field decodes eight sources
// - low disable bits mask pins 7..0
// - high disable bits mask pins 10..8
// - misc bit 2 selects external reference
// - misc bit 1 drives reference output
// - alignment change takes effect immediately
// - done flag set on completion, W1C
module art_result_trigger
  import art_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int PINS   = 11
)(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [7:0]        trigger_flags,
  output logic                   conv_start,
  input  wire logic              conv_done,
  input  wire logic [9:0]        conv_magnitude,
  input  wire logic              conv_reversed,
  output logic                   bipolar_select,
  output logic [2:0]             comparator_cfg,
  input  wire logic [PINS-1:0]   port_pin_raw,
  output logic [PINS-1:0]        port_pin_read,
  output logic [PINS-1:0]        pin_buffer_off,
  output logic                   ext_ref_in_on,
  output logic                   int_ref_out_on,
  output logic                   current_source_on
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0]  control_b_reg;
  logic [7:0]  pin_input_off_low_reg;
  logic [2:0]  pin_input_off_high_reg;
  logic [2:0]  misc_reg;
  logic        converter_on_reg;
  logic        auto_trigger_on_reg;
  logic        result_left_align_reg;
  logic        start_req_reg;
  logic        conversion_done_flag_reg;
  logic        busy_reg;
  logic        lock_reg;
  logic [9:0]  conversion_result_reg;
  logic        trig_prev_reg;
  logic        conv_start_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;

  logic        wr_fire;
  logic        rd_fire;
  logic        wr_low;
  logic        wr_ok;
  logic [7:0]  wbyte;
  logic [7:0]  result_low_byte;
  logic [7:0]  result_high_byte;
  logic [2:0]  trigger_source_select;
  logic        trig_sel;
  logic        trig_edge;
  logic        free_run_hit;
  logic        start_now;
  logic        done_take;
  logic [9:0]  conversion_result_next;
  logic [8:0]  bip_mag;
  logic        rd_low;
  logic        rd_high;
  logic [31:0] rdata_next;
  logic        rd_ok;

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite handshake
  // address and data taken together, one write outstanding at a time
  assign wr_fire       = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready  = wr_fire;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign rd_fire       = s_axi_arvalid && !rvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  // registers are one byte wide, only lane 0 matters
  assign wr_low        = wr_fire && s_axi_wstrb[0];
  assign wbyte         = s_axi_wdata[7:0];

  always_comb
  begin
    wr_ok = 1'b0;
    if (s_axi_awaddr == ART_OFF_RES_LOW || s_axi_awaddr == ART_OFF_RES_HIGH)
      wr_ok = 1'b1;
    else if (s_axi_awaddr == ART_OFF_CTRL_B || s_axi_awaddr == ART_OFF_DIN_LOW)
      wr_ok = 1'b1;
    else if (s_axi_awaddr == ART_OFF_DIN_HIGH || s_axi_awaddr == ART_OFF_MISC)
      wr_ok = 1'b1;
    else if (s_axi_awaddr == ART_OFF_CTRL_A || s_axi_awaddr == ART_OFF_STATUS)
      wr_ok = 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= ART_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_ok ? ART_RESP_OKAY : ART_RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      control_b_reg          <= ART_BYTE_ZERO;
      pin_input_off_low_reg  <= ART_BYTE_ZERO;
      pin_input_off_high_reg <= '0;
      misc_reg               <= '0;
      converter_on_reg       <= 1'b0;
      auto_trigger_on_reg    <= 1'b0;
      result_left_align_reg  <= 1'b0;
    end
    else if (wr_low)
    begin
      if (s_axi_awaddr == ART_OFF_CTRL_B)
        control_b_reg <= wbyte & ART_CB_WMASK;
      else if (s_axi_awaddr == ART_OFF_DIN_LOW)
        pin_input_off_low_reg <= wbyte;
      else if (s_axi_awaddr == ART_OFF_DIN_HIGH)
        pin_input_off_high_reg <= wbyte[ART_DIH_HI:ART_DIH_LO];
      else if (s_axi_awaddr == ART_OFF_MISC)
        misc_reg <= wbyte[ART_MISC_EXT_REF:ART_MISC_ISRC];
      else if (s_axi_awaddr == ART_OFF_CTRL_A)
      begin
        converter_on_reg      <= wbyte[ART_CA_ON];
        auto_trigger_on_reg   <= wbyte[ART_CA_AUTO];
        result_left_align_reg <= wbyte[ART_CA_LEFT];
      end
    end
  end

  // start request is a write-one strobe, served on the next cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      start_req_reg <= 1'b0;
    else
      start_req_reg <= wr_low && s_axi_awaddr == ART_OFF_CTRL_A
                       && wbyte[ART_CA_START];
  end

  assign bipolar_select        = control_b_reg[ART_CB_BIPOLAR];
  assign comparator_cfg        = control_b_reg[ART_CB_CMP_HI:ART_CB_CMP_LO];
  assign trigger_source_select = control_b_reg[ART_CB_TRIG_HI:ART_CB_TRIG_LO];
  assign ext_ref_in_on     = misc_reg[ART_MISC_EXT_REF];
  assign int_ref_out_on    = misc_reg[ART_MISC_INT_OUT];
  assign current_source_on = misc_reg[ART_MISC_ISRC];

  ////////////////////////////////////////////////////////////////////////////
  // digital input disable per pin
  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++)
    begin : g_pin
      if (gi < 8)
      begin : g_low
        assign pin_buffer_off[gi] = pin_input_off_low_reg[gi];
      end
      else
      begin : g_high
        assign pin_buffer_off[gi] = pin_input_off_high_reg[gi-8];
      end
      assign port_pin_read[gi] = port_pin_raw[gi] && !pin_buffer_off[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // auto trigger
  // flag index equals source code; index 0 stands for free running
  // free running source contributes a constant zero
  assign trig_sel = (trigger_source_select == ART_TRIG_FREE) ? 1'b0
                    : trigger_flags[trigger_source_select];

  // previous selected level, so a source switch looks like an edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      trig_prev_reg <= 1'b0;
    else
      trig_prev_reg <= trig_sel;
  end

  // auto trigger gates the source entirely
  assign trig_edge    = auto_trigger_on_reg && trig_sel && !trig_prev_reg;
  // free running restarts on each accepted completion
  assign free_run_hit = auto_trigger_on_reg && done_take
                        && trigger_source_select == ART_TRIG_FREE;
  // triggers during a conversion are dropped, not queued
  assign start_now    = converter_on_reg && (!busy_reg || done_take)
                        && (start_req_reg || trig_edge || free_run_hit);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      conv_start_reg <= 1'b0;
      busy_reg       <= 1'b0;
    end
    else
    begin
      conv_start_reg <= start_now;
      if (!converter_on_reg)
        busy_reg <= 1'b0;
      else if (start_now)
        busy_reg <= 1'b1;
      else if (conv_done)
        busy_reg <= 1'b0;
    end
  end

  assign conv_start = conv_start_reg;

  ////////////////////////////////////////////////////////////////////////////
  // result capture
  // a completion under lock is thrown away
  assign done_take = conv_done && busy_reg && !lock_reg;
  assign bip_mag   = conv_magnitude[8:0];

  always_comb
  begin
    conversion_result_next = conv_magnitude;
    // sign plus nine magnitude bits, two's complement
    if (bipolar_select)
      conversion_result_next = conv_reversed ? 10'(-{1'b0, bip_mag})
                                             : {1'b0, bip_mag};
    else if (conv_reversed)
      conversion_result_next = ART_RES_SAT;
  end

  // load on completion, zero from reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      conversion_result_reg <= '0;
    else if (done_take)
      conversion_result_reg <= conversion_result_next;
  end

  // set on completion wins over the write-one clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      conversion_done_flag_reg <= 1'b0;
    else if (done_take)
      conversion_done_flag_reg <= 1'b1;
    else if (wr_low && s_axi_awaddr == ART_OFF_STATUS && wbyte[ART_ST_DONE])
      conversion_done_flag_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // result bytes and read lock

  // alignment applied at read time, no stored copy to go stale
  always_comb
  begin
    if (result_left_align_reg)
    begin
      result_high_byte = conversion_result_reg[9:2];
      result_low_byte  = {conversion_result_reg[1:0], 6'h00};
    end
    else
    begin
      result_high_byte = {6'h00, conversion_result_reg[9:8]};
      result_low_byte  = conversion_result_reg[7:0];
    end
  end

  assign rd_low  = rd_fire && s_axi_araddr == ART_OFF_RES_LOW;
  assign rd_high = rd_fire && s_axi_araddr == ART_OFF_RES_HIGH;

  // low read locks, high read releases
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      lock_reg <= 1'b0;
    else if (rd_high)
      lock_reg <= 1'b0;
    else if (rd_low)
      lock_reg <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data
  always_comb
  begin
    rdata_next = '0;
    rd_ok      = 1'b1;
    if (s_axi_araddr == ART_OFF_RES_LOW)
      rdata_next[7:0] = result_low_byte;
    else if (s_axi_araddr == ART_OFF_RES_HIGH)
      rdata_next[7:0] = result_high_byte;
    else if (s_axi_araddr == ART_OFF_CTRL_B)
      rdata_next[7:0] = control_b_reg;
    else if (s_axi_araddr == ART_OFF_DIN_LOW)
      rdata_next[7:0] = pin_input_off_low_reg;
    else if (s_axi_araddr == ART_OFF_DIN_HIGH)
      rdata_next[ART_DIH_HI:ART_DIH_LO] = pin_input_off_high_reg;
    else if (s_axi_araddr == ART_OFF_MISC)
      rdata_next[ART_MISC_EXT_REF:ART_MISC_ISRC] = misc_reg;
    else if (s_axi_araddr == ART_OFF_CTRL_A)
    begin
      rdata_next[ART_CA_ON]   = converter_on_reg;
      rdata_next[ART_CA_AUTO] = auto_trigger_on_reg;
      rdata_next[ART_CA_LEFT] = result_left_align_reg;
    end
    else if (s_axi_araddr == ART_OFF_STATUS)
    begin
      rdata_next[ART_ST_DONE] = conversion_done_flag_reg;
      rdata_next[ART_ST_BUSY] = busy_reg;
      rdata_next[ART_ST_LOCK] = lock_reg;
    end
    else
      rd_ok = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= ART_RESP_OKAY;
    end
    else if (rd_fire)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rdata_next;
      rresp_reg  <= rd_ok ? ART_RESP_OKAY : ART_RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_reg <= 1'b0;
  end

endmodule

/* tb/art_result_trigger_asserts.sv */
`timescale 1ns/10ps
module art_result_trigger_asserts
  import art_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int PINS   = 11
)(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic [3:0]        s_axi_wstrb,
  input wire logic              s_axi_wvalid,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              conv_start,
  input wire logic [PINS-1:0]   port_pin_raw,
  input wire logic [PINS-1:0]   port_pin_read,
  input wire logic [PINS-1:0]   pin_buffer_off,
  input wire logic              ext_ref_in_on,
  input wire logic              int_ref_out_on
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic rd_take;
  logic wr_take;
  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wstrb[0];
  //////////////////////////////////////////////////////////////////////////////
  property p_rd_answer; rd_take |=> s_axi_rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_rd_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
  property p_wr_answer; wr_take |=> s_axi_bvalid; endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
  property p_pin_mask; 1'h1 |-> port_pin_read == (port_pin_raw & ~pin_buffer_off); endproperty
  a_pin_mask: assert property (p_pin_mask) else $error("pin mask wrong");
  property p_start_pulse; conv_start |=> !conv_start; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start too long");
  property p_cb_rsv; rd_take && s_axi_araddr == ART_OFF_CTRL_B |=> !s_axi_rdata[3]; endproperty
  a_cb_rsv: assert property (p_cb_rsv) else $error("control_b bit3 set");
  property p_misc_rsv; rd_take && s_axi_araddr == ART_OFF_MISC |=> s_axi_rdata[7:3] == 5'h00;
  endproperty
  a_misc_rsv: assert property (p_misc_rsv) else $error("misc upper set");
  property p_ext_ref; wr_take && s_axi_awaddr == ART_OFF_MISC
    |=> ext_ref_in_on == $past(s_axi_wdata[2]); endproperty
  a_ext_ref: assert property (p_ext_ref) else $error("ext ref wrong");
  property p_int_ref; wr_take && s_axi_awaddr == ART_OFF_MISC
    |=> int_ref_out_on == $past(s_axi_wdata[1]); endproperty
  a_int_ref: assert property (p_int_ref) else $error("int ref wrong");
  property p_unmapped; rd_take && s_axi_araddr > ART_OFF_STATUS
    |=> s_axi_rresp == ART_RESP_SLVERR && s_axi_rdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read wrong");
endmodule

bind art_result_trigger art_result_trigger_asserts #(.ADDR_W(ADDR_W), .PINS(PINS)) u_chk (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wstrb, .s_axi_wvalid, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .conv_start, .port_pin_raw, .port_pin_read, .pin_buffer_off, .ext_ref_in_on,
  .int_ref_out_on
);

/* tb/art_result_trigger_tb.sv */
`timescale 1ns/10ps
module art_result_trigger_tb;
  import art_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, conv_start, conv_done, conv_reversed, bipolar_select;
  logic        ext_ref_in_on, int_ref_out_on, current_source_on;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, trigger_flags;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  comparator_cfg;
  logic [9:0]  conv_magnitude;
  logic [10:0] port_pin_raw, port_pin_read, pin_buffer_off;
  int          num_errors, n_checks, cycles, starts;

  art_result_trigger uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .trigger_flags, .conv_start, .conv_done,
    .conv_magnitude, .conv_reversed, .bipolar_select, .comparator_cfg, .port_pin_raw,
    .port_pin_read, .pin_buffer_off, .ext_ref_in_on, .int_ref_out_on, .current_source_on);

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    aclk = 1'h0;
    forever #4 aclk = ~aclk;
  end

  // hang guard, whole run is a few hundred cycles
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      summarize();
    end
    if (conv_start === 1'h1)
      starts++;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %s exp %h got %h", what, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do @(posedge aclk); while (s_axi_awready !== 1'h1 || s_axi_wready !== 1'h1);
    s_axi_awvalid <= 1'h0;
    s_axi_wvalid <= 1'h0;
    // late ready so the response has to hold
    do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h1;
    @(posedge aclk);
    s_axi_bready <= 1'h0;
    chk($sformatf("bresp %h", a), 32'(er), 32'(s_axi_bresp));
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h1;
    @(posedge aclk);
    s_axi_rready <= 1'h0;
    chk($sformatf("rd %h", a), e, s_axi_rdata);
    chk($sformatf("rresp %h", a), 32'(er), 32'(s_axi_rresp));
  endtask

  task automatic conv(input logic [9:0] m, input logic rev);
    @(posedge aclk);
    conv_done <= 1'h1;
    conv_magnitude <= m;
    conv_reversed <= rev;
    @(posedge aclk);
    conv_done <= 1'h0;
  endtask

  // start lands two edges after the write, four is ample
  task automatic chk_starts(input int n);
    repeat (4) @(posedge aclk);
    chk("starts", 32'(n), 32'(starts));
    starts = 0;
  endtask

  task automatic flags(input logic [7:0] f);
    @(posedge aclk);
    trigger_flags <= f;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {conv_done, conv_reversed, conv_magnitude, trigger_flags} = 20'h00000;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    port_pin_raw = 11'h7FF;
    aresetn = 1'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    for (int i = 0; i < 8; i++)
      rdc(8'(i * 4), 32'h0);
    rdc(8'h20, 32'h0, ART_RESP_SLVERR);
    wr(8'h24, 32'hFF, ART_RESP_SLVERR);
    wr(ART_OFF_CTRL_B, 32'hFF);
    rdc(ART_OFF_CTRL_B, 32'hF7);
    chk("bipolar", 32'h1, 32'(bipolar_select));
    chk("cmp cfg", 32'h7, 32'(comparator_cfg));
    wr(ART_OFF_CTRL_B, 32'h0);
    wr(ART_OFF_DIN_LOW, 32'hA5);
    wr(ART_OFF_DIN_HIGH, 32'h70);
    rdc(ART_OFF_DIN_HIGH, 32'h70);
    chk("pin read", 32'h05A, 32'(port_pin_read));
    chk("buf off", 32'h7A5, 32'(pin_buffer_off));
    wr(ART_OFF_MISC, 32'hFF);
    rdc(ART_OFF_MISC, 32'h07);
    chk("refs", 32'h7, 32'({ext_ref_in_on, int_ref_out_on, current_source_on}));
    // software start, right aligned
    wr(ART_OFF_CTRL_A, 32'h9);
    chk_starts(1);
    conv(10'h2C5, 1'h0);
    rdc(ART_OFF_STATUS, 32'h1);
    rdc(ART_OFF_RES_HIGH, 32'h02);
    rdc(ART_OFF_RES_LOW, 32'hC5);
    rdc(ART_OFF_STATUS, 32'h5);
    wr(ART_OFF_STATUS, 32'h1);
    rdc(ART_OFF_STATUS, 32'h4);
    wr(ART_OFF_CTRL_A, 32'h9);
    chk_starts(1);
    conv(10'h011, 1'h0);
    rdc(ART_OFF_STATUS, 32'h4);
    wr(ART_OFF_CTRL_A, 32'h5);
    rdc(ART_OFF_RES_LOW, 32'h40);
    rdc(ART_OFF_RES_HIGH, 32'hB1);
    rdc(ART_OFF_STATUS, 32'h0);
    wr(ART_OFF_CTRL_A, 32'h9);
    conv(10'h155, 1'h1);
    rdc(ART_OFF_RES_LOW, 32'hFF);
    rdc(ART_OFF_RES_HIGH, 32'h03);
    wr(ART_OFF_CTRL_B, 32'h80);
    wr(ART_OFF_CTRL_A, 32'h9);
    conv(10'h005, 1'h1);
    rdc(ART_OFF_RES_LOW, 32'hFB);
    rdc(ART_OFF_RES_HIGH, 32'h03);
    wr(ART_OFF_CTRL_A, 32'h9);
    conv(10'h305, 1'h0);
    rdc(ART_OFF_RES_LOW, 32'h05);
    rdc(ART_OFF_RES_HIGH, 32'h01);
    chk_starts(3);
    // auto trigger off: flag edges do nothing
    wr(ART_OFF_CTRL_B, 32'h2);
    wr(ART_OFF_CTRL_A, 32'h1);
    flags(8'h04);
    chk_starts(0);
    flags(8'h00);
    wr(ART_OFF_CTRL_A, 32'h3);
    for (int s = 1; s < 8; s++)
    begin
      wr(ART_OFF_CTRL_B, 32'(s));
      flags(8'(1 << s));
      chk_starts(1);
      conv(10'h0, 1'h0);
      chk_starts(0);
      flags(8'h00);
    end
    wr(ART_OFF_CTRL_B, 32'h1);
    flags(8'h08);
    chk_starts(0);
    wr(ART_OFF_CTRL_B, 32'h3);
    chk_starts(1);
    conv(10'h0, 1'h0);
    // done flag is set here, free running must not fire by itself
    wr(ART_OFF_CTRL_B, 32'h0);
    chk_starts(0);
    wr(ART_OFF_CTRL_A, 32'hB);
    conv(10'h0, 1'h0);
    chk_starts(2);
    wr(ART_OFF_CTRL_A, 32'h0);
    summarize();
  end
endmodule
